// *** hw/periodic_match_timer_port.sv ***
// Compare-match timer channel 0 with a 16-pin general I/O port,
// reached over AXI4-Lite. Assumes one clock and synchronous pins.
// Function
// - Channel holds a 16-bit counter raising periodic interrupt requests.
// - Counter advances by one on each divided peripheral clock tick.
// - Clock select 0,1 picks peripheral clock divided by thirty-two.
// - Start bit 0 at 1 makes channel 0 count.
// - Start bit 1 at 0 keeps channel 1 stopped; bits 15-2 reserved.
// - Counter equal to period sets the match flag, bit 7.
// - Only hardware sets the flag; software only clears it.
// - Interrupt request only while enable bit 6 is 1.
// - Period register sets the match count and interrupt interval.
// - Counting continues after a match, so matches recur.
// - Timer leaves standby only while standby bit 12 is 0.
// - General port offers sixteen individually configurable pins.
// - Function-select bit at 0 makes a pin a general port pin.
// - Direction bit at 1 makes the pin an output.
// - Direction bits ignored for pins given to another function.
// - General output pins drive the written data bit.
// - Reading data returns pin level for general input pins.
`include "pmt_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module periodic_match_timer_port
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                srst,
	// AXI4-Lite write address and data
	input  wire logic [`AXI_AW-1:0]  s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read
	input  wire logic [`AXI_AW-1:0]  s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Port pins and the alternate function behind them
	input  wire logic [15:0]         pinIn,
	output logic [15:0]              pinOut,
	output logic [15:0]              pinOe,
	input  wire logic [15:0]         altOut,
	input  wire logic [15:0]         altOe,
	// Compare match interrupt request
	output logic                     matchIrq
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Byte-lane merge into a 16-bit register
	function automatic logic [15:0] laneMerge(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0])
			res[7:0] = wd[7:0];
		if (strb[1])
			res[15:8] = wd[15:8];
		return res;
	endfunction : laneMerge

	// Only the low eight words are mapped
	function automatic logic isMapped(input logic [`AXI_AW-1:0] a);
		return (a[`AXI_AW-1:5] == '0);
	endfunction : isMapped

	// Prescaler terminal count per clock select
	function automatic logic [8:0] divLimit(input logic [1:0] cks);
		case (cks)
			`CKS_DIV8:   return `LIM_DIV8;
			`CKS_DIV32:  return `LIM_DIV32;
			`CKS_DIV128: return `LIM_DIV128;
			default:     return `LIM_DIV512;
		endcase
	endfunction : divLimit

	// ----------------------------------------
	// State
	// ----------------------------------------
	pmt_pkg::wr_state_e     wrState_q;
	pmt_pkg::rd_state_e     rdState_q;
	logic                   awHeld_q;
	logic                   wHeld_q;
	logic [`AXI_AW-1:0]     awAddr_q;
	logic [31:0]            wData_q;
	logic [3:0]             wStrb_q;
	logic [1:0]             bResp_q;
	logic [31:0]            rData_q;
	logic [1:0]             rResp_q;
	logic [15:0]            standby_q;
	logic [1:0]             start_q;
	pmt_pkg::csr_s          csr_q;
	logic [15:0]            count_q;
	logic [15:0]            period_q;
	logic [8:0]             presc_q;
	logic [15:0]            pinFunc_q;
	logic [15:0]            dir_q;
	logic [15:0]            data_q;
	logic [15:0]            pinOut_q;
	logic [15:0]            pinOe_q;
	logic                   irq_q;

	logic                   wrEn;
	logic [2:0]             wrIdx;
	logic                   wrOk;
	logic                   runOk;
	logic                   tick;
	logic                   matchEv;
	logic                   countWr;
	logic                   csrWr;
	logic [15:0]            gpioOut;
	logic [15:0]            readWord;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------

	// Address and data may arrive in either order; each is held once taken
	assign s_axi_awready = !awHeld_q && (wrState_q == pmt_pkg::WS_IDLE);
	assign s_axi_wready  = !wHeld_q && (wrState_q == pmt_pkg::WS_IDLE);
	assign s_axi_bvalid  = (wrState_q == pmt_pkg::WS_RESP);
	assign s_axi_bresp   = bResp_q;
	assign wrEn  = awHeld_q && wHeld_q;
	assign wrIdx = awAddr_q[4:2];
	assign wrOk  = wrEn && isMapped(awAddr_q);

	// Write channel capture and response
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			wrState_q <= pmt_pkg::WS_IDLE;
			awHeld_q  <= 1'b0;
			wHeld_q   <= 1'b0;
			awAddr_q  <= '0;
			wData_q   <= '0;
			wStrb_q   <= '0;
			bResp_q   <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			case (wrState_q)
				pmt_pkg::WS_IDLE:
				begin
					if (wrEn)
					begin
						awHeld_q  <= 1'b0;
						wHeld_q   <= 1'b0;
						bResp_q   <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
						wrState_q <= pmt_pkg::WS_RESP;
					end
				end
				pmt_pkg::WS_RESP:
				begin
					if (s_axi_bready)
						wrState_q <= pmt_pkg::WS_IDLE;
				end
				default: wrState_q <= pmt_pkg::WS_IDLE;
			endcase
		end
	end

	assign s_axi_arready = (rdState_q == pmt_pkg::RS_IDLE);
	assign s_axi_rvalid  = (rdState_q == pmt_pkg::RS_DATA);
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;

	// General input pins read the pin, general outputs the latch
	assign gpioOut = dir_q & ~pinFunc_q;

	// Read data mux; reserved bits read as zero
	always_comb
	begin
		readWord = '0;
		case (s_axi_araddr[4:2])
			`OFS_STANDBY: readWord[15:0] = standby_q;
			`OFS_START:   readWord[1:0]  = start_q;
			`OFS_CSR:
			begin
				readWord[`BIT_FLAG]  = csr_q.matchFlag;
				readWord[`BIT_IRQEN] = csr_q.matchIrqEnable;
				readWord[1:0]        = csr_q.clockSelect;
			end
			`OFS_COUNT:   readWord[15:0] = count_q;
			`OFS_PERIOD:  readWord[15:0] = period_q;
			`OFS_PINFUNC: readWord[15:0] = pinFunc_q;
			`OFS_DIR:     readWord[15:0] = dir_q;
			`OFS_DATA:    readWord[15:0] = (data_q & gpioOut) | (pinIn & ~gpioOut);
			default:      readWord = '0;
		endcase
	end

	// Read channel: one cycle to data, held until rready
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rdState_q <= pmt_pkg::RS_IDLE;
			rData_q   <= '0;
			rResp_q   <= `RESP_OKAY;
		end
		else
		begin
			case (rdState_q)
				pmt_pkg::RS_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						rData_q   <= isMapped(s_axi_araddr) ? readWord : '0;
						rResp_q   <= isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
						rdState_q <= pmt_pkg::RS_DATA;
					end
				end
				pmt_pkg::RS_DATA:
				begin
					if (s_axi_rready)
						rdState_q <= pmt_pkg::RS_IDLE;
				end
				default: rdState_q <= pmt_pkg::RS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	assign countWr = wrOk && (wrIdx == `OFS_COUNT) && (wStrb_q[1:0] != 2'h0);
	assign csrWr   = wrOk && (wrIdx == `OFS_CSR) && wStrb_q[0];

	// Software-written configuration; reserved start bits are dropped
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			standby_q <= `RST_STANDBY;
			start_q   <= '0;
			period_q  <= `RST_PERIOD;
			pinFunc_q <= `RST_ZERO;
			dir_q     <= `RST_ZERO;
			data_q    <= `RST_ZERO;
			csr_q.matchIrqEnable <= 1'b0;
			csr_q.clockSelect    <= `CKS_DIV8;
		end
		else if (wrOk)
		begin
			case (wrIdx)
				`OFS_STANDBY: standby_q <= laneMerge(standby_q, wData_q, wStrb_q);
				`OFS_START:
				begin
					if (wStrb_q[0])
						start_q <= wData_q[1:0];
				end
				`OFS_CSR:
				begin
					if (wStrb_q[0])
					begin
						csr_q.matchIrqEnable <= wData_q[`BIT_IRQEN];
						csr_q.clockSelect    <= wData_q[1:0];
					end
				end
				`OFS_PERIOD:  period_q  <= laneMerge(period_q, wData_q, wStrb_q);
				`OFS_PINFUNC: pinFunc_q <= laneMerge(pinFunc_q, wData_q, wStrb_q);
				`OFS_DIR:     dir_q     <= laneMerge(dir_q, wData_q, wStrb_q);
				`OFS_DATA:    data_q    <= laneMerge(data_q, wData_q, wStrb_q);
				default:      standby_q <= standby_q;
			endcase
		end
	end

	// ----------------------------------------
	// Count clock and counter
	// ----------------------------------------

	// Standby freezes the counter and holds the prescaler at zero
	assign runOk   = start_q[`BIT_RUN0] && !standby_q[`BIT_STANDBY];
	assign tick    = runOk && (presc_q == divLimit(csr_q.clockSelect));
	assign matchEv = tick && (count_q == period_q);

	// Prescaler restarts whenever the channel is stopped
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			presc_q <= '0;
		else if (!runOk || tick)
			presc_q <= '0;
		else
			presc_q <= presc_q + 9'h001;
	end

	// A software write beats the tick so a reload is never lost
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			count_q <= `RST_ZERO;
		else if (countWr)
			count_q <= laneMerge(count_q, wData_q, wStrb_q);
		else if (matchEv)
			count_q <= `RST_ZERO;
		else if (tick)
			count_q <= count_q + 16'h0001;
	end

	// Match flag: set wins over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			csr_q.matchFlag <= 1'b0;
		else if (matchEv)
			csr_q.matchFlag <= 1'b1;
		else if (csrWr && !wData_q[`BIT_FLAG])
			csr_q.matchFlag <= 1'b0;
	end

	// Interrupt request follows flag and enable with one register stage
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			irq_q <= 1'b0;
		else
			irq_q <= csr_q.matchFlag && csr_q.matchIrqEnable;
	end
	assign matchIrq = irq_q;

	// ----------------------------------------
	// General port pins
	// ----------------------------------------

	// Pins given to another function take its drive; direction ignored
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pinOut_q <= '0;
			pinOe_q  <= '0;
		end
		else
		begin
			pinOut_q <= (data_q & ~pinFunc_q) | (altOut & pinFunc_q);
			pinOe_q  <= gpioOut | (altOe & pinFunc_q);
		end
	end
	assign pinOut = pinOut_q;
	assign pinOe  = pinOe_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_DIV32_GAP: assert property (
		(tick && csr_q.clockSelect == `CKS_DIV32 && !wrEn) |=> !tick [*8])
		else $error("tick spacing too short at divide by 32");
	AST_COUNT_STEP: assert property (
		(tick && !matchEv && !countWr) |=> count_q == $past(count_q) + 16'h0001)
		else $error("counter did not step by one");
	AST_STOPPED: assert property (
		(!runOk && !countWr) |=> $stable(count_q))
		else $error("counter moved while stopped");
	AST_STANDBY: assert property (
		standby_q[`BIT_STANDBY] |-> !tick)
		else $error("tick in standby");
	AST_FLAG_SET: assert property (
		matchEv |=> csr_q.matchFlag)
		else $error("match did not set flag");
	AST_FLAG_CLEAR: assert property (
		$fell(csr_q.matchFlag) |-> $past(csrWr) && !$past(wData_q[`BIT_FLAG]))
		else $error("flag fell without a clearing write");
	AST_IRQ: assert property (
		(csr_q.matchFlag && csr_q.matchIrqEnable) |=> matchIrq)
		else $error("enabled flag gave no request");
	AST_NO_IRQ: assert property (
		!csr_q.matchIrqEnable |=> !matchIrq)
		else $error("request while disabled");
	AST_WRAP: assert property (
		(matchEv && !countWr) |=> count_q == 16'h0000)
		else $error("counter did not restart after match");
	AST_PIN_OUT: assert property (
		gpioOut[0] |=> pinOut[0] == $past(data_q[0]) && pinOe[0])
		else $error("general output not driven");
	AST_BRESP: assert property (
		wrEn |=> s_axi_bvalid)
		else $error("write response late");

	COV_MATCH: cover property (matchEv);
	COV_CLEAR: cover property ($fell(csr_q.matchFlag));
	COV_IRQ:   cover property ($rose(matchIrq));

endmodule : periodic_match_timer_port

`default_nettype wire

// *** hw/pmt_defines.svh ***
// Constants for the periodic match timer and general port block.
// Assumes a 32-bit AXI4-Lite bus; each register sits in the low 16 bits.
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// ----------------------------------------
// Register word offsets (address bits 4:2)
// ----------------------------------------
`define OFS_STANDBY   3'h0
`define OFS_START     3'h1
`define OFS_CSR       3'h2
`define OFS_COUNT     3'h3
`define OFS_PERIOD    3'h4
`define OFS_PINFUNC   3'h5
`define OFS_DIR       3'h6
`define OFS_DATA      3'h7

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BIT_STANDBY   12
`define BIT_RUN0      0
`define BIT_RUN1      1
`define BIT_FLAG      7
`define BIT_IRQEN     6
`define RST_STANDBY   16'h1000
`define RST_PERIOD    16'hFFFF
`define RST_ZERO      16'h0000

// ----------------------------------------
// Prescaler limits (divide ratio minus one)
// ----------------------------------------
`define CKS_DIV8      2'h0
`define CKS_DIV32     2'h1
`define CKS_DIV128    2'h2
`define LIM_DIV8      9'h007
`define LIM_DIV32     9'h01F
`define LIM_DIV128    9'h07F
`define LIM_DIV512    9'h1FF

// ----------------------------------------
// Bus widths and responses
// ----------------------------------------
`define AXI_AW        12
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** hw/pmt_pkg.sv ***
// Types shared by the periodic match timer and general port block.
// Assumes pmt_defines.svh for numeric constants.
package pmt_pkg;

	// Channel 0 control/status fields
	typedef struct packed {
		logic       matchFlag;
		logic       matchIrqEnable;
		logic [1:0] clockSelect;
	} csr_s;

	// Bus write channel state
	typedef enum logic [0:0] {
		WS_IDLE = 1'b0,
		WS_RESP = 1'b1
	} wr_state_e;

	// Bus read channel state
	typedef enum logic [0:0] {
		RS_IDLE = 1'b0,
		RS_DATA = 1'b1
	} rd_state_e;

endpackage : pmt_pkg

// *** tb/led_pair_model.sv ***
// LED pair on port pins 0 and 1, plus the board levels on every released pin.
// Assumes the port drives its pins synchronously to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module led_pair_model
(
	// Drive from the port
	input  wire logic [15:0] pinOut,
	input  wire logic [15:0] pinOe,
	// Level the board puts on released pins, changed by the bench
	input  wire logic [15:0] extLevel,
	// Wire level seen back by the port, and the lamps
	output logic      [15:0] pinIn,
	output logic      [1:0]  ledOn
);
	// A released pin shows the board level, never the last driven value
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
	// Lamps light on a high level
	assign ledOn = pinIn[1:0];
endmodule : led_pair_model
`default_nettype wire

// *** tb/periodic_match_timer_port_test.sv ***
// Self-checking bench for the match timer and general port block.
// Assumes the design files and the LED model are compiled before it.
`include "pmt_defines.svh"
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errCount++; \
	$display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end

module periodic_match_timer_port_test;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, matchIrq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ledOn;
	logic [31:0] s_axi_rdata;
	logic [15:0] pinIn, pinOut, pinOe;
	logic [15:0] altOut = 16'h0000, altOe = 16'h0000, extLevel = 16'h0000;
	logic [15:0] lfsr = 16'h002F;
	logic        prevIrq = 1'b0;
	int          errCount = 0, checked = 0, cyc = 0;
	int          riseQ[$];

	always #2.5 ref_clk = ~ref_clk;

	periodic_match_timer_port u_dut
	(
		.ref_clk(ref_clk), .srst(srst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut), .altOe(altOe),
		.matchIrq(matchIrq)
	);

	led_pair_model u_leds
	(
		.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn), .ledOn(ledOn)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Fixed-seed shift register keeps every run identical
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], ^(lfsr & 16'hB400)};
		return lfsr;
	endfunction : rnd

	function automatic logic [11:0] ad(input logic [2:0] o);
		return {7'h00, o, 2'b00};
	endfunction : ad

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// Cycle count, interrupt edge log and hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		prevIrq <= matchIrq;
		if (matchIrq && !prevIrq)
			riseQ.push_back(cyc);
		if (cyc == 20000)
		begin
			errCount++;
			final_report();
		end
	end

	// ----------------------------------------
	// Bus master
	// ----------------------------------------
	// Address and data offered together; each dropped only once taken
	task automatic axWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : axWrite

	task automatic axRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : axRead

	task automatic wrReg(input logic [2:0] o, input logic [15:0] d);
		logic [1:0] r;
		axWrite(ad(o), {16'h0000, d}, r);
		`CHK(r, `RESP_OKAY)
	endtask : wrReg

	task automatic rdReg(input logic [2:0] o, output logic [15:0] d);
		logic [31:0] x;
		logic [1:0]  r;
		axRead(ad(o), x, r);
		`CHK(r, `RESP_OKAY)
		d = x[15:0];
	endtask : rdReg

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [15:0] v, f, d, w, gen, oeE, outE, lvl, cnt;
		logic [31:0] x;
		logic [1:0]  r, ledE;
		int          hits;
		logic [15:0] rstVal [7] = '{16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
			16'h0000, 16'h0000};
		extLevel = rnd();
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			rdReg(i[2:0], v);
			`CHK(v, rstVal[i])
		end
		rdReg(`OFS_DATA, v);
		`CHK(v, extLevel)
		// Unmapped places answer with an error and no data
		axRead(12'h020, x, r);
		`CHK({r, x}, {`RESP_SLVERR, 32'h0000_0000})
		axWrite(12'h040, 32'h0000_FFFF, r);
		`CHK(r, `RESP_SLVERR)
		// Reserved start bits drop; standby keeps the counter still
		wrReg(`OFS_START, 16'hFFFF);
		rdReg(`OFS_START, v);
		`CHK(v, 16'h0003)
		repeat (100) @(posedge ref_clk);
		rdReg(`OFS_COUNT, v);
		`CHK(v, 16'h0000)
		wrReg(`OFS_START, 16'h0000);
		// Random pin set-ups, with all-general output as the corner case
		for (int i = 0; i < 6; i++)
		begin
			f = (i == 0) ? 16'h0000 : rnd();
			d = (i == 0) ? 16'hFFFF : rnd();
			w = rnd();
			altOut   <= rnd();
			altOe    <= rnd();
			extLevel <= rnd();
			wrReg(`OFS_PINFUNC, f);
			wrReg(`OFS_DIR, d);
			wrReg(`OFS_DATA, w);
			repeat (2) @(posedge ref_clk);
			gen  = ~f & d;
			oeE  = gen | (f & altOe);
			outE = (gen & w) | (f & altOut);
			lvl  = (oeE & outE) | (~oeE & extLevel);
			`CHK(pinOe, oeE)
			`CHK(pinOut & oeE, outE & oeE)
			rdReg(`OFS_DATA, v);
			`CHK(v, (gen & w) | (~gen & lvl))
		end
		// LED set-up first, start last; period 3 at divide by 32
		ledE = 2'b01;
		wrReg(`OFS_PINFUNC, 16'h0000);
		wrReg(`OFS_DATA, {14'h0000, ledE});
		wrReg(`OFS_DIR, 16'h0003);
		wrReg(`OFS_PERIOD, 16'h0003);
		wrReg(`OFS_CSR, 16'h0041);
		wrReg(`OFS_STANDBY, 16'h0000);
		riseQ.delete();
		wrReg(`OFS_START, 16'h0001);
		for (int k = 0; k < 4; k++)
		begin
			while (riseQ.size() <= k)
				@(posedge ref_clk);
			rdReg(`OFS_CSR, v);
			`CHK(v, 16'h00C1)
			if (k == 0)
			begin
				wrReg(`OFS_CSR, 16'h00C1);
				rdReg(`OFS_CSR, v);
				`CHK(v[7], 1'b1)
			end
			wrReg(`OFS_CSR, 16'h0041);
			rdReg(`OFS_CSR, v);
			`CHK(v, 16'h0041)
			ledE = ~ledE;
			wrReg(`OFS_DATA, {14'h0000, ledE});
			repeat (2) @(posedge ref_clk);
			`CHK(ledOn, ledE)
		end
		// Interval is (period + 1) ticks of 32 cycles, every time
		for (int k = 1; k < 4; k++)
			`CHK(riseQ[k] - riseQ[k - 1], 128)
		// Flag still sets with the enable off, but no request
		wrReg(`OFS_CSR, 16'h0001);
		hits = 0;
		repeat (300)
		begin
			@(posedge ref_clk);
			hits += int'(matchIrq);
		end
		`CHK(hits, 0)
		rdReg(`OFS_CSR, v);
		`CHK(v[7], 1'b1)
		wrReg(`OFS_CSR, 16'h00C1);
		repeat (3) @(posedge ref_clk);
		`CHK(matchIrq, 1'b1)
		// Back into standby: the counter freezes
		wrReg(`OFS_STANDBY, 16'h1000);
		rdReg(`OFS_COUNT, cnt);
		repeat (200) @(posedge ref_clk);
		rdReg(`OFS_COUNT, v);
		`CHK(v, cnt)
		final_report();
	end
endmodule : periodic_match_timer_port_test
`default_nettype wire
